// File: rtl/fmt_pkg.sv
package fmt_pkg;
	// Sample width on the shared bus
	localparam int SAMPLE_W = 12;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h30;
	localparam logic [7:0] TX_FMT_IDX = 8'h31;
	localparam logic [7:0] RX_FMT_IDX = 8'h32;
	localparam logic [7:0] STAT_IDX = 8'h3F;
	// Reset value of every writable register
	localparam logic [7:0] REG_RESET = 8'h00;
	// Writable bit masks; unused bits read as zero
	localparam logic [7:0] RX_WMASK = 8'hBF;
	localparam logic [7:0] TX_WMASK = 8'h03;
	localparam logic [7:0] CTRL_WMASK = 8'h03;
	// Receive format control fields
	localparam int RX_SINGLE_EDGE_BIT = 7;
	localparam int RX_CLK_SRC_HI = 5;
	localparam int RX_CLK_SRC_LO = 4;
	localparam int RX_LAUNCH_EDGE_BIT = 3;
	localparam int RX_MARKER_POL_BIT = 2;
	localparam int RX_PAIR_ORDER_BIT = 1;
	localparam int RX_NUM_FMT_BIT = 0;
	// Transmit format control fields
	localparam int TX_PAIR_ORDER_BIT = 1;
	localparam int TX_NUM_FMT_BIT = 0;
	// Port control fields
	localparam int CTRL_HD_ONE_CLK_BIT = 0;
	localparam int CTRL_TX_MODE_BIT = 1;
	// Receive clock source encodings
	localparam logic [1:0] CLK_SRC_PATH = 2'h2;
	localparam logic [1:0] CLK_SRC_DLL = 2'h3;
	// Configuration word carried into the link domain
	localparam int CFG_W = 18;
	localparam int CFG_TX_LSB = 8;
	localparam int CFG_CTRL_LSB = 16;
	// Status word carried back from the link domain
	localparam int STAT_W = 9;
	localparam int STAT_RUN_BIT = 8;
endpackage

// File: rtl/cdc_word_sync.sv
`timescale 1ns/1ps
// Toggle handshake that moves a whole word between two clock domains
module cdc_word_sync #(
	parameter int W = 8
) (
	input wire logic src_clk,
	input wire logic src_rst_n,
	input wire logic [W-1:0] src_data,
	input wire logic dst_clk,
	input wire logic dst_rst_n,
	output logic [W-1:0] dst_data
);

	////////////////////////////////////////////////////////////////////////
	// Source side
	logic [W-1:0] held_q; // Word under transfer, stable while busy
	logic req_q; // Toggles once per word
	logic ack_s1_q; // First synchroniser stage of ack
	logic ack_s2_q; // Second synchroniser stage of ack
	logic ack_q; // Destination toggle echoing req

	wire busy = req_q != ack_s2_q;
	wire launch = ~busy && (src_data != held_q);

	// Capture a new word only when the previous one has been taken
	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			held_q <= '0;
			req_q <= 1'b0;
		end else if (launch) begin
			held_q <= src_data;
			req_q <= ~req_q;
		end
	end

	// Bring the echo back; only the second stage is looked at
	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Destination side
	logic req_s1_q; // First synchroniser stage of req
	logic req_s2_q; // Second stage, safe to use
	logic req_s3_q; // Delayed copy for change detection

	// Synchronise the request toggle
	always_ff @(posedge dst_clk or negedge dst_rst_n) begin
		if (!dst_rst_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// Held word is quiet here, so a multi-bit capture is safe
	always_ff @(posedge dst_clk or negedge dst_rst_n) begin
		if (!dst_rst_n) begin
			dst_data <= '0;
			ack_q <= 1'b0;
		end else if (req_s2_q != req_s3_q) begin
			dst_data <= held_q;
			ack_q <= req_s2_q;
		end
	end

endmodule

// File: rtl/rx_tx_data_port_formatting.sv
`timescale 1ns/1ps
// Functional notes
// - Transmit format bit: offset binary or twos complement
// - Transmit order bit one: I first, Q second
// - Transmit order bit zero: Q first, I second
// - Receive edge bit: zero both edges, one single
// - Clock source: off, off, path clock, DLL
// - Port clock shows transmit clock in half-duplex one-clock transmit
// - Launch edge bit: zero falling, one rising
// - Marker polarity: zero low-high, one high-low
// - Receive I/Q sequential; order bit picks first
// - Receive format: straight binary or twos complement
module rx_tx_data_port_formatting #(
	parameter int DW = fmt_pkg::SAMPLE_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic link_clk,
	input wire logic [DW-1:0] rx_i_sample,
	input wire logic [DW-1:0] rx_q_sample,
	output logic rx_clock_source_dll,
	output logic shared_port_clock,
	input wire logic tx_port_clock,
	input wire logic [DW-1:0] shared_sample_bus_in,
	output logic [DW-1:0] shared_sample_bus_out,
	output logic shared_sample_bus_oe,
	output logic rx_pair_marker,
	input wire logic tx_word_valid,
	output logic [DW-1:0] tx_i_word,
	output logic [DW-1:0] tx_q_word,
	output logic tx_pair_valid
);
	import fmt_pkg::*;

	// Flip the sign bit unless the word is already twos complement
	function automatic logic [DW-1:0] fmt_word(input logic [DW-1:0] w, input logic twos);
		fmt_word = twos ? w : {~w[DW-1], w[DW-2:0]};
	endfunction

	// Word-aligned register decode
	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] idx);
		reg_hit = adr[7:2] == idx[5:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus-side registers
	logic [7:0] rx_fmt_q; // Receive format control
	logic [7:0] tx_fmt_q; // Transmit format control
	logic [7:0] ctrl_q; // Half-duplex and direction control
	logic ack_q; // Wishbone acknowledge
	logic [31:0] rd_q; // Read data held for the master
	logic [STAT_W-1:0] stat_b; // Link status seen in the bus domain

	// Decode
	wire req = wb_cyc_i & wb_stb_i;
	wire hit_rx = reg_hit(wb_adr_i, RX_FMT_IDX);
	wire hit_tx = reg_hit(wb_adr_i, TX_FMT_IDX);
	wire hit_ctrl = reg_hit(wb_adr_i, CTRL_IDX);
	wire hit_stat = reg_hit(wb_adr_i, STAT_IDX);
	// A write lands at the edge where the master sees ack
	wire wr_low = req & wb_we_i & ack_q & wb_sel_i[0];
	wire [7:0] wr_byte = wb_dat_i[7:0];

	// Read selection; unmapped words read zero
	wire [31:0] rd_word = hit_rx ? {24'h000000, rx_fmt_q} :
		hit_tx ? {24'h000000, tx_fmt_q} :
		hit_ctrl ? {24'h000000, ctrl_q} :
		hit_stat ? {23'h0, stat_b} : 32'h00000000;

	// One wait state, then ack for one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Read data sampled together with raising ack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 32'h00000000;
		end else if (req & ~ack_q) begin
			rd_q <= rd_word;
		end
	end

	// Writable registers; unused bits never stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_fmt_q <= REG_RESET;
			tx_fmt_q <= REG_RESET;
			ctrl_q <= REG_RESET;
		end else begin
			if (wr_low & hit_rx) begin
				rx_fmt_q <= wr_byte & RX_WMASK;
			end
			if (wr_low & hit_tx) begin
				tx_fmt_q <= wr_byte & TX_WMASK;
			end
			if (wr_low & hit_ctrl) begin
				ctrl_q <= wr_byte & CTRL_WMASK;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rd_q;

	////////////////////////////////////////////////////////////////////////
	// Link reset and domain crossings
	logic [1:0] link_rst_q; // Release of reset aligned to the link clock
	logic [CFG_W-1:0] cfg_l; // Configuration in the link domain
	logic [STAT_W-1:0] stat_l; // Status assembled in the link domain

	// Asserted at once, released two link edges later
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_rst_q <= 2'h0;
		end else begin
			link_rst_q <= {link_rst_q[0], 1'b1};
		end
	end

	wire link_rst_n = link_rst_q[1];
	wire [CFG_W-1:0] cfg_b = {ctrl_q[1:0], tx_fmt_q, rx_fmt_q};

	// Whole configuration word crosses at once, never a torn mix
	cdc_word_sync #(
		.W(CFG_W)
	) cfg_sync (
		.src_clk(clk),
		.src_rst_n(rst_n),
		.src_data(cfg_b),
		.dst_clk(link_clk),
		.dst_rst_n(link_rst_n),
		.dst_data(cfg_l)
	);

	// Status comes back the same way
	cdc_word_sync #(
		.W(STAT_W)
	) stat_sync (
		.src_clk(link_clk),
		.src_rst_n(link_rst_n),
		.src_data(stat_l),
		.dst_clk(clk),
		.dst_rst_n(rst_n),
		.dst_data(stat_b)
	);

	// Link-side field view
	wire [7:0] rx_cfg = cfg_l[7:0];
	wire [7:0] tx_cfg = cfg_l[CFG_TX_LSB +: 8];
	wire [1:0] ctrl_cfg = cfg_l[CFG_CTRL_LSB +: 2];
	wire sdr = rx_cfg[RX_SINGLE_EDGE_BIT];
	wire [1:0] clk_src = rx_cfg[RX_CLK_SRC_HI:RX_CLK_SRC_LO];
	wire launch_rise = rx_cfg[RX_LAUNCH_EDGE_BIT];
	wire marker_pol = rx_cfg[RX_MARKER_POL_BIT];
	wire rx_i_first = rx_cfg[RX_PAIR_ORDER_BIT];
	wire rx_twos = rx_cfg[RX_NUM_FMT_BIT];
	wire tx_i_first = tx_cfg[TX_PAIR_ORDER_BIT];
	wire tx_twos = tx_cfg[TX_NUM_FMT_BIT];
	wire hd_one_clk = ctrl_cfg[CTRL_HD_ONE_CLK_BIT];
	wire tx_mode = ctrl_cfg[CTRL_TX_MODE_BIT];

	////////////////////////////////////////////////////////////////////////
	// Receive launch
	logic port_clk_q; // Divided receive port clock
	logic slot_q; // Zero before the first word of a pair
	logic [DW-1:0] second_q; // Second word waiting for its slot
	logic [DW-1:0] bus_out_q; // Word on the shared bus
	logic marker_q; // Pair marker level
	logic word_launch_q; // A new word went out at this edge
	logic oe_q; // Bus drive enable
	logic run_q; // Receive clock running
	logic dll_q; // Clock source is the DLL

	// Both disabled codes stop the receive clock
	wire rx_run = clk_src[1];
	// Clock parks low while stopped
	wire port_clk_d = rx_run & ~port_clk_q;
	// Every toggle carries a word, or only the chosen edge does
	wire advance = rx_run & (~sdr | (port_clk_d == launch_rise));
	// Simultaneous I and Q, ordered by the pair order bit
	wire [DW-1:0] first_raw = rx_i_first ? rx_i_sample : rx_q_sample;
	wire [DW-1:0] second_raw = rx_i_first ? rx_q_sample : rx_i_sample;

	// Port clock divider; the pin is derived from it
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			port_clk_q <= 1'b0;
		end else begin
			port_clk_q <= port_clk_d;
		end
	end

	// Pair slot tracking; a stop restarts at the first word
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			slot_q <= 1'b0;
		end else if (!rx_run) begin
			slot_q <= 1'b0;
		end else if (advance) begin
			slot_q <= ~slot_q;
		end
	end

	// Word and marker launch
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bus_out_q <= '0;
			second_q <= '0;
			marker_q <= 1'b0;
		end else if (advance && !slot_q) begin
			bus_out_q <= fmt_word(first_raw, rx_twos);
			second_q <= fmt_word(second_raw, rx_twos);
			marker_q <= marker_pol;
		end else if (advance) begin
			bus_out_q <= second_q;
			// Invert the first word's level, so a polarity change mid-pair still flips
			marker_q <= ~marker_q;
		end
	end

	// Registered flags; bus is released while transmitting
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			word_launch_q <= 1'b0;
			oe_q <= 1'b0;
			run_q <= 1'b0;
			dll_q <= 1'b0;
		end else begin
			word_launch_q <= advance;
			oe_q <= rx_run & ~tx_mode;
			run_q <= rx_run;
			dll_q <= clk_src == CLK_SRC_DLL;
		end
	end

	// Half-duplex single-clock transmit borrows the pin
	wire show_tx_clk = hd_one_clk & tx_mode;
	assign shared_port_clock = show_tx_clk ? tx_port_clock : port_clk_q;
	assign shared_sample_bus_out = bus_out_q;
	assign shared_sample_bus_oe = oe_q;
	assign rx_pair_marker = marker_q;
	assign rx_clock_source_dll = dll_q;

	////////////////////////////////////////////////////////////////////////
	// Transmit pairing
	logic tx_slot_q; // One when the first word is held
	logic [DW-1:0] tx_hold_q; // First word of the pair
	logic [DW-1:0] tx_i_q; // Assembled I
	logic [DW-1:0] tx_q_q; // Assembled Q
	logic tx_valid_q; // Pair ready pulse
	logic [7:0] pair_cnt_q; // Pairs taken, wraps

	wire tx_take = tx_mode & tx_word_valid;
	wire tx_done = tx_take & tx_slot_q;
	wire [DW-1:0] tx_first_fmt = fmt_word(tx_hold_q, tx_twos);
	wire [DW-1:0] tx_second_fmt = fmt_word(shared_sample_bus_in, tx_twos);

	// Words pair strictly in arrival order
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_slot_q <= 1'b0;
			tx_hold_q <= '0;
		end else if (!tx_mode) begin
			tx_slot_q <= 1'b0;
		end else if (tx_take) begin
			tx_slot_q <= ~tx_slot_q;
			if (!tx_slot_q) begin
				tx_hold_q <= shared_sample_bus_in;
			end
		end
	end

	// Steer the pair by the transmit order bit
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_i_q <= '0;
			tx_q_q <= '0;
		end else if (tx_done) begin
			tx_i_q <= tx_i_first ? tx_first_fmt : tx_second_fmt;
			tx_q_q <= tx_i_first ? tx_second_fmt : tx_first_fmt;
		end
	end

	// Pair pulse and counter for status
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_valid_q <= 1'b0;
			pair_cnt_q <= 8'h00;
		end else begin
			tx_valid_q <= tx_done;
			pair_cnt_q <= pair_cnt_q + {7'h00, tx_done};
		end
	end

	assign tx_i_word = tx_i_q;
	assign tx_q_word = tx_q_q;
	assign tx_pair_valid = tx_valid_q;
	assign stat_l = {run_q, pair_cnt_q};

	////////////////////////////////////////////////////////////////////////
	// Checks
	wire hold_msb = tx_hold_q[DW-1];
	wire first_msb = first_raw[DW-1];

	chk_tx_format: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		tx_done && tx_i_first && !tx_twos |=> tx_i_word[DW-1] != $past(hold_msb))
		else $error("offset binary transmit word not converted");

	chk_tx_i_first: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		tx_done && tx_i_first |=> tx_pair_valid && tx_i_word == $past(tx_first_fmt))
		else $error("I-first pair steered wrongly");

	chk_tx_q_first: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		tx_done && !tx_i_first |=> tx_pair_valid && tx_q_word == $past(tx_first_fmt))
		else $error("Q-first pair steered wrongly");

	chk_single_edge: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		advance && sdr && $stable(rx_cfg) |=> !advance || $changed(rx_cfg))
		else $error("single edge mode launched on two edges in a row");

	chk_double_edge: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		rx_run && !sdr ##1 $stable(rx_cfg) |-> word_launch_q && port_clk_q != $past(port_clk_q))
		else $error("double edge mode missed a word");

	chk_clock_off: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		!clk_src[1] |=> !word_launch_q ##1 (!run_q || clk_src[1]))
		else $error("receive words launched with clock disabled");

	chk_port_clk_mux: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		shared_port_clock == ((hd_one_clk && tx_mode) ? tx_port_clock : port_clk_q))
		else $error("wrong clock on shared port pin");

	chk_launch_edge: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		word_launch_q && $past(sdr) && $past(rx_run) |-> port_clk_q == $past(launch_rise))
		else $error("receive word launched on the wrong edge");

	chk_marker_pol: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		advance && !slot_q |=> rx_pair_marker == $past(marker_pol))
		else $error("pair marker polarity wrong on first word");

	chk_rx_order: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		advance && !slot_q && rx_i_first && rx_twos |=> shared_sample_bus_out == $past(rx_i_sample))
		else $error("I-first receive word wrong");

	chk_rx_format: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		advance && !slot_q && !rx_twos |=> shared_sample_bus_out[DW-1] != $past(first_msb))
		else $error("straight binary receive word not converted");

	chk_marker_flip: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		advance && slot_q |=> rx_pair_marker != $past(rx_pair_marker) && slot_q == 1'b0)
		else $error("marker did not change within the pair");

endmodule

// File: verif/bb_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Baseband processor model on the far side of the shared sample bus
module bb_partner #(
	parameter int DW = 12
) (
	input wire logic link_clk,
	input wire logic dev_oe,
	input wire logic [DW-1:0] dev_out,
	output logic [DW-1:0] bus_level,
	output logic word_valid
);
	// Word we drive; the inverse of the last one once released
	logic [DW-1:0] drv_q;
	// Pins carry the device word while it drives, ours otherwise
	assign bus_level = dev_oe ? dev_out : drv_q;
	// Idle at start
	initial begin
		drv_q = '0;
		word_valid = 1'b0;
	end
	// One pair, first and second word on consecutive link edges
	task automatic send_pair(input logic [DW-1:0] first, input logic [DW-1:0] second);
		@(posedge link_clk);
		drv_q <= first;
		word_valid <= 1'b1;
		@(posedge link_clk);
		drv_q <= second;
		@(posedge link_clk);
		word_valid <= 1'b0;
		// A stale word must not pass for a fresh one
		drv_q <= ~second;
	endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Self-checking bench for the sample port formatting block
module tb;
	import fmt_pkg::*;
	localparam int DW = SAMPLE_W;
	// Clocks, reset and register bus
	logic clk, link_clk, tpc, rst_n;
	logic wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_rdat, rd;
	// Sample side
	logic dll, pclk, bus_oe, marker, twv, tpv;
	logic [DW-1:0] rx_i, rx_q, bus_lvl, bus_out, txi, txq;
	// Register addresses and writable masks
	logic [7:0] ra [3] = '{8'hC8, 8'hC4, 8'hC0};
	logic [7:0] wm [3] = '{RX_WMASK, TX_WMASK, CTRL_WMASK};
	// Receive setups covering every edge mode, order, polarity and format
	logic [7:0] rcfg [4] = '{8'h23, 8'h24, 8'hAA, 8'hB5};
	// Transmit words, one with the sign bit set
	logic [DW-1:0] wa = 12'h1F0;
	logic [DW-1:0] wz = 12'h8A3;
	int failures, checks;
	////////////////////////////////////////////////////////////////
	rx_tx_data_port_formatting #(.DW(DW)) dut_u (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .link_clk(link_clk), .rx_i_sample(rx_i), .rx_q_sample(rx_q),
		.rx_clock_source_dll(dll), .shared_port_clock(pclk), .tx_port_clock(tpc),
		.shared_sample_bus_in(bus_lvl), .shared_sample_bus_out(bus_out),
		.shared_sample_bus_oe(bus_oe), .rx_pair_marker(marker), .tx_word_valid(twv),
		.tx_i_word(txi), .tx_q_word(txq), .tx_pair_valid(tpv)
	);
	bb_partner #(.DW(DW)) bb_u (
		.link_clk(link_clk), .dev_oe(bus_oe), .dev_out(bus_out), .bus_level(bus_lvl),
		.word_valid(twv)
	);
	////////////////////////////////////////////////////////////////
	// Bus clock
	always #20 clk = ~clk;
	// Link clock, offset so its edges never meet the bus clock's
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	// Transmit port clock stepped off the link clock
	always @(posedge link_clk) begin
		tpc <= ~tpc;
	end
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic complete_run;
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t sample %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	// Expected word: offset binary flips only the sign bit
	function automatic logic [DW-1:0] fmt(input logic [DW-1:0] s, input logic twos);
		return twos ? s : {~s[DW-1], s[DW-2:0]};
	endfunction
	// Classic single cycle; the request stands until ack is sampled
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			complete_run();
		end else begin
			q = wb_rdat;
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
		end
	endtask
	// Step to just after a link edge, where outputs have settled
	task automatic link_step;
		@(posedge link_clk);
		#1;
	endtask
	// Catch the launch of a first word, then follow the pair
	task automatic rx_pair(input logic [7:0] c);
		int n;
		logic pol, prev;
		logic [DW-1:0] f, s;
		pol = c[RX_MARKER_POL_BIT];
		f = fmt(c[RX_PAIR_ORDER_BIT] ? rx_i : rx_q, c[RX_NUM_FMT_BIT]);
		s = fmt(c[RX_PAIR_ORDER_BIT] ? rx_q : rx_i, c[RX_NUM_FMT_BIT]);
		n = 0;
		do begin
			prev = marker;
			link_step();
			n++;
		end while (!(marker === pol && prev !== pol) && n < 40);
		if (n >= 40) begin
			failures++;
			complete_run();
		end else begin
			cmp_word(bus_out, f);
			cmp_bit(bus_oe, 1'b1);
			cmp_bit(dll, c[RX_CLK_SRC_HI] & c[RX_CLK_SRC_LO]);
			// Single edge: the word must hold across the other port clock edge
			if (c[RX_SINGLE_EDGE_BIT]) begin
				cmp_bit(pclk, c[RX_LAUNCH_EDGE_BIT]);
				link_step();
				cmp_word(bus_out, f);
				cmp_bit(marker, pol);
			end
			link_step();
			cmp_word(bus_out, s);
			cmp_bit(marker, ~pol);
		end
	endtask
	// One transmit pair in half-duplex one-clock transmit mode
	task automatic tx_pair(input logic [1:0] tf);
		int n;
		wb_xfer(1'b1, 8'hC4, {6'h00, tf}, rd);
		wb_xfer(1'b1, 8'hC0, 8'h03, rd);
		repeat (20) @(posedge clk);
		link_step();
		cmp_bit(pclk, tpc);
		cmp_bit(bus_oe, 1'b0);
		n = 0;
		fork
			bb_u.send_pair(wa, wz);
			do begin
				link_step();
				n++;
			end while (tpv !== 1'b1 && n < 20);
		join
		if (n >= 20) begin
			failures++;
			complete_run();
		end else begin
			cmp_word(tf[1] ? txi : txq, fmt(wa, tf[0]));
			cmp_word(tf[1] ? txq : txi, fmt(wz, tf[0]));
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0;
		link_clk = 1'b0;
		tpc = 1'b0;
		rst_n = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'hF;
		wb_wdat = 32'h00000000;
		rx_i = 12'h123;
		rx_q = 12'hA5C;
		failures = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values and writable bits, then back to idle
		for (int k = 0; k < 3; k++) begin
			wb_xfer(1'b0, ra[k], 8'h00, rd);
			cmp_reg(rd, {24'h000000, REG_RESET});
			wb_xfer(1'b1, ra[k], 8'hFF, rd);
			wb_xfer(1'b0, ra[k], 8'h00, rd);
			cmp_reg(rd, {24'h000000, wm[k]});
			wb_xfer(1'b1, ra[k], 8'h00, rd);
		end
		repeat (20) @(posedge clk);
		// Unmapped place and read-only status ignore writes
		wb_xfer(1'b1, 8'h80, 8'hFF, rd);
		wb_xfer(1'b0, 8'h80, 8'h00, rd);
		cmp_reg(rd, 32'h00000000);
		wb_xfer(1'b1, 8'hFC, 8'hFF, rd);
		wb_xfer(1'b0, 8'hFC, 8'h00, rd);
		cmp_reg(rd, 32'h00000000);
		// Low byte lane disabled: the write must not land
		wb_sel <= 4'hE;
		wb_xfer(1'b1, 8'hC4, 8'h03, rd);
		wb_sel <= 4'hF;
		wb_xfer(1'b0, 8'hC4, 8'h00, rd);
		cmp_reg(rd, 32'h00000000);
		// Receive setups; config needs a few cycles to cross
		for (int k = 0; k < 4; k++) begin
			wb_xfer(1'b1, 8'hC8, rcfg[k], rd);
			repeat (20) @(posedge clk);
			rx_pair(rcfg[k]);
		end
		wb_xfer(1'b0, 8'hFC, 8'h00, rd);
		cmp_reg(rd, 32'h00000100);
		// Clock source off parks the port clock low
		wb_xfer(1'b1, 8'hC8, 8'h00, rd);
		repeat (20) @(posedge clk);
		for (int k = 0; k < 16; k++) begin
			link_step();
			cmp_bit(pclk, 1'b0);
		end
		// Both transmit orders in both number formats
		for (int k = 0; k < 4; k++) begin
			tx_pair(k[1:0]);
		end
		wb_xfer(1'b1, 8'hC0, 8'h00, rd);
		repeat (20) @(posedge clk);
		wb_xfer(1'b0, 8'hFC, 8'h00, rd);
		cmp_reg(rd, 32'h00000004);
		complete_run();
	end
	// Hang guard
	initial begin
		#1000000;
		failures++;
		complete_run();
	end
endmodule
